// *** src/szsvc_top.sv ***
`timescale 1ns/1ns
module szsvc_top
   import szsvc_pkg::*;
#(
   parameter logic [31:0] VEC_BASE_LO = 32'h0000_0000,
   parameter logic [31:0] VEC_BASE_HI = 32'hFFF0_0000
) (
   input wire logic CLK_SYS_IN,
   input wire logic NRST_IN,
   input wire logic [REG_AW-1:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [REG_AW-1:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   output logic SVC_INT_OUT
);
   // ********************
   // elaboration checks
   // ********************
   // the vector offset is added, not or-ed, so bases must leave it room
   if (VEC_BASE_LO[12:0] != 13'h0000) begin : g_chk_lo
      $error("low vector base must be 8 KiB aligned");
   end
   if (VEC_BASE_HI[12:0] != 13'h0000) begin : g_chk_hi
      $error("high vector base must be 8 KiB aligned");
   end
   // decode case items are compared at the bus address width
   if (REG_AW != $bits(OFS_INSTR)) begin : g_chk_aw
      $error("register address width differs from the map");
   end
   // the relative offset must fill the same width as the absolute one
   if ($bits(VEC_LEAD) + IB_VIDX_HI - IB_VIDX_LO + 1 + $bits(VEC_PAD)
      != $bits(VEC_ABS_OFS)) begin : g_chk_ofs
      $error("vector offset fields do not add up");
   end

   // ********************
   // state
   // ********************
   typedef struct packed {
      logic aw_got;
      logic [REG_AW-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic go;
      logic [31:0] instr;
      logic [31:0] src;
      logic [31:0] res;
      logic cout;
      logic oflow;
      logic so;
      logic [3:0] cr0;
      logic [31:0] msr;
      logic [31:0] ctr;
      logic [31:0] lr;
      logic [31:0] cia;
      logic last_neg;
      logic last_trap;
      logic last_bad;
      logic [15:0] trap_cnt;
      logic irq;
   } szsvc_st_s;

   szsvc_st_s r;
   szsvc_st_s n;
   szsvc_exec_if x ();

   logic is_neg;
   logic is_trap;
   logic [REG_AW-1:0] w_word;
   logic [REG_AW-1:0] r_word;
   logic [31:0] xer_word;
   logic [31:0] st_word;

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] d,
      input logic [3:0] s
   );
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[8*i +: 8] = d[8*i +: 8];
         end
      end
      return m;
   endfunction

   // ********************
   // execution units
   // ********************
   assign x.instr = r.instr;
   assign x.src = r.src;
   assign x.msr = r.msr;
   assign x.cia = r.cia;
   assign x.cin = r.cout;
   assign x.so_in = r.so;

   szsvc_arith u_arith (
      .x(x)
   );

   szsvc_trap #(
      .VEC_BASE_LO(VEC_BASE_LO),
      .VEC_BASE_HI(VEC_BASE_HI)
   ) u_trap (
      .x(x)
   );

   // ********************
   // decode
   // ********************
   always_comb begin
      is_trap = (r.instr[IB_OPC_HI:IB_OPC_LO] == OPC_TRAP);
      is_neg = (r.instr[IB_OPC_HI:IB_OPC_LO] == OPC_NEG_ADD)
         && (r.instr[IB_XO_HI:IB_XO_LO] == XO_NEG_ADD);
      w_word = {r.aw_addr[REG_AW-1:2], 2'b00};
      r_word = {S_AXI_ARADDR_IN[REG_AW-1:2], 2'b00};
   end

   // ********************
   // read views of packed state
   // ********************
   always_comb begin
      xer_word = WORD_ZERO;
      xer_word[XER_SO] = r.so;
      xer_word[XER_OFLOW] = r.oflow;
      xer_word[XER_COUT] = r.cout;
      st_word = WORD_ZERO;
      st_word[ST_NEG] = r.last_neg;
      st_word[ST_TRAP] = r.last_trap;
      st_word[ST_BAD] = r.last_bad;
      st_word[31:ST_CNT_LO] = r.trap_cnt;
   end

   // ********************
   // next state
   // ********************
   always_comb begin
      n = r;
      n.go = 1'b0;
      n.irq = 1'b0;

      // write channel: address and data latched independently
      if (S_AXI_AWVALID_IN && r.awready) begin
         n.aw_got = 1'b1;
         n.aw_addr = S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && r.wready) begin
         n.w_got = 1'b1;
         n.w_data = S_AXI_WDATA_IN;
         n.w_strb = S_AXI_WSTRB_IN;
      end
      if (r.bvalid && S_AXI_BREADY_IN) begin
         n.bvalid = 1'b0;
      end
      // a register write never meets an execution: bvalid stands in that cycle
      if (r.aw_got && r.w_got && !r.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         unique case (w_word)
            OFS_INSTR: begin
               n.instr = merge(r.instr, r.w_data, r.w_strb);
               n.go = 1'b1;
            end
            OFS_SRC: n.src = merge(r.src, r.w_data, r.w_strb);
            OFS_XER: begin
               n.so = r.w_strb[3] ? r.w_data[XER_SO] : r.so;
               n.oflow = r.w_strb[3] ? r.w_data[XER_OFLOW] : r.oflow;
               n.cout = r.w_strb[3] ? r.w_data[XER_COUT] : r.cout;
            end
            OFS_CR0: n.cr0 = r.w_strb[0] ? r.w_data[3:0] : r.cr0;
            OFS_MSR: n.msr = merge(r.msr, r.w_data, r.w_strb);
            OFS_CTR: n.ctr = merge(r.ctr, r.w_data, r.w_strb);
            OFS_LR: n.lr = merge(r.lr, r.w_data, r.w_strb);
            OFS_CIA: n.cia = merge(r.cia, r.w_data, r.w_strb);
            OFS_RESULT, OFS_STATUS: n.bresp = RESP_OKAY;
            default: n.bresp = RESP_SLVERR;
         endcase
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      // read channel: one word per request, answered next cycle
      if (r.rvalid && S_AXI_RREADY_IN) begin
         n.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_IN && r.arready) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         unique case (r_word)
            OFS_INSTR: n.rdata = r.instr;
            OFS_SRC: n.rdata = r.src;
            OFS_RESULT: n.rdata = r.res;
            OFS_XER: n.rdata = xer_word;
            OFS_CR0: n.rdata = {28'h000_0000, r.cr0};
            OFS_MSR: n.rdata = r.msr;
            OFS_CTR: n.rdata = r.ctr;
            OFS_LR: n.rdata = r.lr;
            OFS_CIA: n.rdata = r.cia;
            OFS_STATUS: n.rdata = st_word;
            default: begin
               n.rdata = WORD_ZERO;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end
      n.arready = !n.rvalid;

      // execution, one cycle after the instruction word lands
      if (r.go) begin
         n.last_neg = is_neg;
         n.last_trap = is_trap;
         n.last_bad = !is_neg && !is_trap;
         if (is_neg) begin
            n.res = x.sum;
            n.cout = x.cout;
            if (r.instr[IB_OE]) begin
               n.oflow = x.oflow_out;
               n.so = x.so_out;
            end
            if (r.instr[IB_FLAG]) begin
               n.cr0 = x.cr0_out;
            end
            n.cia = x.lnk;
         end else if (is_trap) begin
            // exception register and condition field are not touched here
            n.irq = 1'b1;
            n.ctr = x.ctr;
            n.trap_cnt = r.trap_cnt + 16'h0001;
            n.cia = x.tgt;
            if (r.instr[IB_LINK]) begin
               n.lr = x.lnk;
            end
            n.msr = x.msr_out;
         end
      end
   end

   // ********************
   // registers
   // ********************
   always_ff @(posedge CLK_SYS_IN) begin
      if (!NRST_IN) begin
         r <= '0;
         r.msr <= MSR_RST;
      end else begin
         r <= n;
      end
   end

   // ********************
   // outputs
   // ********************
   assign S_AXI_AWREADY_OUT = r.awready;
   assign S_AXI_WREADY_OUT = r.wready;
   assign S_AXI_BRESP_OUT = r.bresp;
   assign S_AXI_BVALID_OUT = r.bvalid;
   assign S_AXI_ARREADY_OUT = r.arready;
   assign S_AXI_RDATA_OUT = r.rdata;
   assign S_AXI_RRESP_OUT = r.rresp;
   assign S_AXI_RVALID_OUT = r.rvalid;
   // single-cycle pulse; the receiver must not expect it to stand
   assign SVC_INT_OUT = r.irq;
endmodule

// *** pkg/szsvc_pkg.sv ***
package szsvc_pkg;
   // ********************
   // register map
   // ********************
   localparam int unsigned REG_AW = 8;
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_SRC = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_XER = 8'h0C;
   localparam logic [7:0] OFS_CR0 = 8'h10;
   localparam logic [7:0] OFS_MSR = 8'h14;
   localparam logic [7:0] OFS_CTR = 8'h18;
   localparam logic [7:0] OFS_LR = 8'h1C;
   localparam logic [7:0] OFS_CIA = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ********************
   // instruction fields (bit 0 of the word is the lsb)
   // ********************
   localparam int IB_OPC_HI = 31;
   localparam int IB_OPC_LO = 26;
   localparam int IB_OE = 10;
   localparam int IB_XO_HI = 9;
   localparam int IB_XO_LO = 1;
   localparam int IB_FLAG = 0;
   localparam int IB_ABS = 1;
   localparam int IB_LINK = 0;
   localparam int IB_VIDX_HI = 11;
   localparam int IB_VIDX_LO = 5;
   localparam int IB_IMM_HI = 15;
   localparam logic [5:0] OPC_NEG_ADD = 6'h1F;
   localparam logic [5:0] OPC_TRAP = 6'h11;
   localparam logic [8:0] XO_NEG_ADD = 9'h0C8;

   // ********************
   // status register fields
   // ********************
   localparam int XER_SO = 31;
   localparam int XER_OFLOW = 30;
   localparam int XER_COUT = 29;
   localparam int CR0_NEG = 3;
   localparam int CR0_POS = 2;
   localparam int CR0_ZERO = 1;
   localparam int CR0_SO = 0;
   localparam int MSR_XIRQ = 15;
   localparam int MSR_USER = 14;
   localparam int MSR_FPX = 11;
   localparam int MSR_VBASE = 6;
   localparam int MSR_HALF = 16;
   localparam int ST_NEG = 0;
   localparam int ST_TRAP = 1;
   localparam int ST_BAD = 2;
   localparam int ST_CNT_LO = 16;

   // ********************
   // vector and sequencing constants
   // ********************
   localparam logic VEC_LEAD = 1'b1;
   localparam logic [4:0] VEC_PAD = 5'h00;
   localparam logic [12:0] VEC_ABS_OFS = 13'h1FE0;
   localparam logic [31:0] INSN_STEP = 32'h0000_0004;
   localparam logic [31:0] MSR_RST = 32'h0000_0000;
endpackage

// *** pkg/szsvc_exec_if.sv ***
`timescale 1ns/1ns
interface szsvc_exec_if;
   logic [31:0] instr;
   logic [31:0] src;
   logic [31:0] msr;
   logic [31:0] cia;
   logic cin;
   logic so_in;
   logic [31:0] sum;
   logic cout;
   logic oflow_out;
   logic so_out;
   logic [3:0] cr0_out;
   logic [31:0] tgt;
   logic [31:0] ctr;
   logic [31:0] lnk;
   logic [31:0] msr_out;
   modport core (
      output instr, src, msr, cia, cin, so_in,
      input sum, cout, oflow_out, so_out, cr0_out, tgt, ctr, lnk, msr_out
   );
   modport arith (
      input instr, src, cin, so_in,
      output sum, cout, oflow_out, so_out, cr0_out
   );
   modport trap (
      input instr, msr, cia,
      output tgt, ctr, lnk, msr_out
   );
endinterface

// *** src/szsvc_arith.sv ***
`timescale 1ns/1ns
module szsvc_arith
   import szsvc_pkg::*;
(
   szsvc_exec_if.arith x
);
   logic [31:0] opa;
   logic [32:0] wide;
   logic oflow;
   logic so;

   always_comb begin
      opa = ~x.src;
      // inverted source plus carry plus a zero word
      wide = {1'b0, opa} + {32'h0000_0000, x.cin} + {1'b0, WORD_ZERO};
      // zero addend is positive, so only a sign flip of opa can overflow
      oflow = (opa[31] == WORD_ZERO[31]) && (wide[31] != opa[31]);
      // summary copy only advances when the overflow-record form runs
      so = x.instr[IB_OE] ? (x.so_in | oflow) : x.so_in;
      x.sum = wide[31:0];
      x.cout = wide[32];
      x.oflow_out = oflow;
      x.so_out = so;
      x.cr0_out[CR0_NEG] = wide[31];
      x.cr0_out[CR0_POS] = !wide[31] && (wide[31:0] != WORD_ZERO);
      x.cr0_out[CR0_ZERO] = (wide[31:0] == WORD_ZERO);
      x.cr0_out[CR0_SO] = so;
   end
endmodule

// *** src/szsvc_trap.sv ***
`timescale 1ns/1ns
module szsvc_trap
   import szsvc_pkg::*;
#(
   parameter logic [31:0] VEC_BASE_LO = 32'h0000_0000,
   parameter logic [31:0] VEC_BASE_HI = 32'hFFF0_0000
) (
   szsvc_exec_if.trap x
);
   logic [31:0] base;
   logic [12:0] ofs;

   always_comb begin
      base = x.msr[MSR_VBASE] ? VEC_BASE_HI : VEC_BASE_LO;
      // spare data fields around the index do not steer the target, but bits 15:0 all go into ctr
      if (x.instr[IB_ABS]) begin
         ofs = VEC_ABS_OFS;
      end else begin
         ofs = {VEC_LEAD, x.instr[IB_VIDX_HI:IB_VIDX_LO], VEC_PAD};
      end
      x.tgt = base + {19'h0_0000, ofs};
      x.ctr = {x.instr[IB_IMM_HI:0], x.msr[MSR_HALF-1:0]};
      x.lnk = x.cia + INSN_STEP;
      x.msr_out = x.msr;
      x.msr_out[MSR_XIRQ] = 1'b0;
      x.msr_out[MSR_USER] = 1'b0;
      x.msr_out[MSR_FPX] = 1'b0;
   end
endmodule

// *** test/szsvc_top_sva.sv ***
`timescale 1ns/1ns
// ****
// port checker
// ****
module szsvc_top_sva
   import szsvc_pkg::*;
(
   input wire logic CLK_SYS_IN,
   input wire logic NRST_IN,
   input wire logic S_AXI_AWVALID_IN,
   input wire logic S_AXI_AWREADY_OUT,
   input wire logic S_AXI_WVALID_IN,
   input wire logic S_AXI_WREADY_OUT,
   input wire logic [1:0] S_AXI_BRESP_OUT,
   input wire logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [REG_AW-1:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   input wire logic S_AXI_ARREADY_OUT,
   input wire logic [31:0] S_AXI_RDATA_OUT,
   input wire logic [1:0] S_AXI_RRESP_OUT,
   input wire logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic SVC_INT_OUT
);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!NRST_IN);

   a_svc_one_cycle: assert property (SVC_INT_OUT |=> !SVC_INT_OUT)
      else $error("trap pulse longer than one cycle");
   // a pulse only ever follows a register write, never a read
   a_svc_after_write: assert property ($rose(SVC_INT_OUT) |->
      ($past(S_AXI_BVALID_OUT, 1) || $past(S_AXI_BVALID_OUT, 2)))
      else $error("trap pulse without a preceding write");
   a_b_holds: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
      |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
      else $error("write response dropped early");
   a_r_holds: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
      |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read data dropped early");
   a_ar_blocked: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
      else $error("read address accepted while data pending");
   a_rd_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
      else $error("read answer late");
   a_wr_answer: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
      && S_AXI_WREADY_OUT |-> ##2 S_AXI_BVALID_OUT)
      else $error("write answer late");
   a_aw_drops: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT |=> !S_AXI_AWREADY_OUT)
      else $error("write address ready stayed high");
   a_rd_unmapped: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
      && S_AXI_ARADDR_IN >= 8'h28 |=> S_AXI_RRESP_OUT == RESP_SLVERR
      && S_AXI_RDATA_OUT == WORD_ZERO)
      else $error("unmapped read not refused");

   c_trap: cover property (SVC_INT_OUT);
   c_slverr: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == RESP_SLVERR);
   c_read: cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
endmodule

bind szsvc_top szsvc_top_sva u_sva (.CLK_SYS_IN, .NRST_IN, .S_AXI_AWVALID_IN,
   .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BRESP_OUT,
   .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN,
   .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT,
   .S_AXI_RREADY_IN, .SVC_INT_OUT);

// *** test/szsvc_top_tb.sv ***
`timescale 1ns/1ns
module szsvc_top_tb import szsvc_pkg::*;;
   // ****
   // bench state
   // ****
   localparam logic [31:0] B_LO = 32'h0010_0000;
   localparam logic [31:0] B_HI = 32'hFFF0_0000;
   localparam logic [31:0] NOP_CR = 32'h4C00_0382;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic bready = 1'b0;
   logic arv = 1'b0;
   logic rready = 1'b0;
   logic awr, wrd, bv, arr, rv, svc;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, dat, ins, m, tgt;
   int err_total = 0;
   int n_checks = 0;
   int svc_n = 0;
   // src, xer before, {oe,flag}, result, xer after, field zero after
   logic [31:0] nt [7][6] = '{
      '{32'h9000_3000, 32'hA000_0000, 32'h0, 32'h6FFF_D000, 32'h8000_0000, 32'h6},
      '{32'hB004_3000, 32'h6000_0000, 32'h1, 32'h4FFB_D000, 32'h4000_0000, 32'h4},
      '{32'hEFFF_FFFF, 32'h4000_0000, 32'h2, 32'h1000_0000, 32'h0000_0000, 32'h6},
      '{32'h70FB_6500, 32'h0000_0000, 32'h3, 32'h8F04_9AFF, 32'h0000_0000, 32'h8},
      '{32'h0000_0000, 32'h2000_0000, 32'h1, 32'h0000_0000, 32'h2000_0000, 32'h2},
      '{32'h8000_0000, 32'h2000_0000, 32'h3, 32'h8000_0000, 32'hC000_0000, 32'h9},
      '{32'h0000_0001, 32'h8000_0000, 32'h3, 32'hFFFF_FFFE, 32'h8000_0000, 32'h9}};
   // trap word (spare fields filled in all but the second), machine state before
   logic [31:0] tt [4][2] = '{'{32'h4400_FFFC, 32'hFFFF_FFFF},
      '{32'h4400_0001, 32'h0000_0040}, '{32'h4400_554A, 32'h0001_4800},
      '{32'h4400_AAB7, 32'hA5A5_A5A5}};

   always #25 clk = ~clk;

   always @(posedge clk) begin
      if (svc === 1'b1) begin
         svc_n <= svc_n + 1;
      end
   end

   szsvc_top #(.VEC_BASE_LO(B_LO), .VEC_BASE_HI(B_HI)) u_szsvc_top (
      .CLK_SYS_IN(clk), .NRST_IN(nrst),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wv),
      .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv),
      .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rready), .SVC_INT_OUT(svc));

   // ****
   // tasks
   // ****
   task automatic stop_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // the edge before raising lets a previous release land first
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awv && awr) begin
            awv <= 1'b0;
         end
         if (wv && wrd) begin
            wv <= 1'b0;
         end
      end while (bv !== 1'b1 && n < 200);
      if (bv !== 1'b1) begin
         err_total++;
      end
      bready <= 1'b0;
      rsp = bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arv && arr) begin
            arv <= 1'b0;
         end
      end while (rv !== 1'b1 && n < 200);
      if (rv !== 1'b1) begin
         err_total++;
      end
      rready <= 1'b0;
      dat = rdata;
      rsp = rresp;
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, 4'hF);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(dat, e);
   endtask

   // ****
   // tests
   // ****
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      rc(OFS_XER, WORD_ZERO);
      rc(OFS_MSR, MSR_RST);
      w(8'h28, 32'hFFFF_FFFF);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      rd(8'h28);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      w(OFS_RESULT, 32'h1234_5678);
      rc(OFS_RESULT, WORD_ZERO);
      // exception bits live in the top byte, so a write without it changes nothing
      wr(OFS_XER, 32'hE000_0000, 4'h7);
      rc(OFS_XER, WORD_ZERO);
      for (int i = 0; i < 7; i++) begin
         w(OFS_XER, nt[i][1]);
         w(OFS_CR0, 32'h0000_0006);
         w(OFS_SRC, nt[i][0]);
         w(OFS_CIA, 32'h0000_0100);
         w(OFS_INSTR, {OPC_NEG_ADD, 15'h0000, nt[i][2][1], XO_NEG_ADD, nt[i][2][0]});
         rc(OFS_RESULT, nt[i][3]);
         rc(OFS_XER, nt[i][4]);
         rc(OFS_CR0, nt[i][5]);
         rc(OFS_STATUS, 32'h0000_0001);
         rc(OFS_CIA, 32'h0000_0104);
      end
      for (int i = 0; i < 4; i++) begin
         ins = tt[i][0];
         m = tt[i][1];
         tgt = (m[6] ? B_HI : B_LO) + (ins[1] ? {19'h0, VEC_ABS_OFS}
            : {19'h0, VEC_LEAD, ins[11:5], VEC_PAD});
         w(OFS_MSR, m);
         w(OFS_CIA, 32'h0000_2000);
         w(OFS_LR, 32'h5A5A_0000);
         w(OFS_XER, 32'hA000_0000);
         w(OFS_CR0, 32'h0000_0009);
         w(OFS_INSTR, NOP_CR);
         rc(OFS_STATUS, {16'(i), 16'h0004});
         w(OFS_CIA, 32'h0000_2000);
         w(OFS_INSTR, ins);
         rc(OFS_CIA, tgt);
         rc(OFS_CTR, {ins[15:0], m[15:0]});
         rc(OFS_LR, ins[0] ? 32'h0000_2004 : 32'h5A5A_0000);
         rc(OFS_MSR, m & 32'hFFFF_37FF);
         rc(OFS_XER, 32'hA000_0000);
         rc(OFS_CR0, 32'h0000_0009);
      end
      chk(32'(svc_n), 32'h0000_0004);
      rc(OFS_STATUS, 32'h0004_0002);
      stop_test();
   end

   // the tests need about five hundred cycles
   initial begin
      #400_000;
      err_total++;
      stop_test();
   end
endmodule
